// *** core/counter_pkg.sv ***
// Constants and types shared by the counter timebase block
package counter_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W  = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_LOW  = 2'h0;
  localparam logic [1:0] ADDR_HIGH = 2'h1;
  localparam logic [1:0] ADDR_MODE = 2'h2;

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MODE_ENABLE_BIT  = 0;
  localparam int MODE_SEL_LSB     = 1;
  localparam int MODE_SEL_MSB     = 3;
  localparam int MODE_FLAG_BIT    = 6;
  localparam int MODE_SUSPEND_BIT = 7;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0]  MODE_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;

  // ----------------------------------------------------------------
  // Prescaler ratios
  // ----------------------------------------------------------------
  localparam int DIV_SLOW = 12;
  localparam int DIV_FAST = 4;
  localparam int DIV_OSC  = 8;

  typedef enum logic [2:0] {
    TB_DIV12    = 3'b000,
    TB_DIV4     = 3'b001,
    TB_TIMER0   = 3'b010,
    TB_ECI      = 3'b011,
    TB_SYSCLK   = 3'b100,
    TB_EXTOSC   = 3'b101,
    TB_LFO      = 3'b110,
    TB_RESERVED = 3'b111
  } timebase_t;

endpackage

// *** core/tick_if.sv ***
// One-cycle tick carried between the timebase helper modules
`timescale 1ns/1ns
interface tick_if;
  logic pulse;
  modport src (output pulse);
  modport dst (input  pulse);
endinterface

// *** core/edge_sync.sv ***
// Two-flop pin synchroniser with a registered edge pulse
`timescale 1ns/1ns
module edge_sync #(
  parameter bit FALLING = 1'b1
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic pin,
  tick_if.src       edge_tick
);

  logic s1_r, s1_nxt;
  logic s2_r, s2_nxt;
  logic s3_r, s3_nxt;
  logic edge_r, edge_nxt;

  // Only s2 and s3 feed the edge test; s1 is read by s2 alone
  always_comb begin
    s1_nxt   = pin;
    s2_nxt   = s1_r;
    s3_nxt   = s2_r;
    edge_nxt = FALLING ? (s3_r & ~s2_r) : (~s3_r & s2_r);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_r   <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
      edge_r <= 1'b0;
    end else begin
      s1_r   <= s1_nxt;
      s2_r   <= s2_nxt;
      s3_r   <= s3_nxt;
      edge_r <= edge_nxt;
    end
  end

  assign edge_tick.pulse = edge_r;

endmodule

// *** core/tick_divider.sv ***
// Counts input ticks and emits one output tick every DIV of them
`timescale 1ns/1ns
module tick_divider #(
  parameter int DIV = 12
) (
  input  wire logic core_clk,
  input  wire logic reset,
  tick_if.dst       in_tick,
  tick_if.src       out_tick
);

  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_r, cnt_nxt;
  logic         out_r, out_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    out_nxt = 1'b0;
    if (in_tick.pulse) begin
      if (cnt_r == LAST) begin
        cnt_nxt = '0;
        out_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign out_tick.pulse = out_r;

endmodule

// *** core/counter_timebase.sv ***
// Sixteen-bit counter with selectable timebase and overflow flag
//
// Summary of operation
// R1 - The count is one 16-bit value seen by software as two byte registers.
// R2 - A low-byte read snapshots the high byte for the next high-byte read.
// R3 - Software reads the low byte first to get a coherent 16-bit value.
// R4 - Reading either count byte never stalls, reloads or drops a count.
// R5 - Wrapping from all ones to zero sets the overflow flag.
// R6 - The interrupt request follows the flag only while its enable is set.
// R7 - Hardware never clears the flag; software clears it.
// R8 - With idle suspend clear the count keeps running in processor idle.
// R9 - Codes 0, 1, 2 and 4 count clock/12, clock/4, timer 0 overflow and clock.
// R10 - Code 3 counts synced falling edges of the count input, max clock/4.
// R11 - Code 5 counts the synchronised external oscillator divided by 8.
// R12 - Code 6 counts the synced slow oscillator over 8; code 7 is reserved.
// R13 - With idle suspend set the count holds while the processor idles.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module counter_timebase (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       cpu_idle,
  input  wire logic       timer0_overflow,
  input  wire logic       external_count_input,
  input  wire logic       ext_osc_in,
  input  wire logic       lfo_in,
  output logic            overflow_irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [1:0] addr,
                               input logic [1:0] target);
    hit = (addr == target);
  endfunction

  logic wr_low;
  logic wr_high;
  logic wr_mode;
  logic rd_low;
  logic rd_high;

  assign wr_low  = reg_wr & hit(reg_addr, counter_pkg::ADDR_LOW);
  assign wr_high = reg_wr & hit(reg_addr, counter_pkg::ADDR_HIGH);
  assign wr_mode = reg_wr & hit(reg_addr, counter_pkg::ADDR_MODE);
  assign rd_low  = reg_rd & hit(reg_addr, counter_pkg::ADDR_LOW);
  assign rd_high = reg_rd & hit(reg_addr, counter_pkg::ADDR_HIGH);

  // ----------------------------------------------------------------
  // Timebase sources
  // ----------------------------------------------------------------
  tick_if always_tick ();
  tick_if div12_tick ();
  tick_if div4_tick ();
  tick_if eci_tick ();
  tick_if osc_edge ();
  tick_if osc8_tick ();
  tick_if lfo_edge ();
  tick_if lfo8_tick ();

  assign always_tick.pulse = 1'b1;

  tick_divider #(.DIV(counter_pkg::DIV_SLOW)) u_div12 (
    .core_clk (core_clk),
    .reset    (reset),
    .in_tick  (always_tick),
    .out_tick (div12_tick)
  );

  tick_divider #(.DIV(counter_pkg::DIV_FAST)) u_div4 (
    .core_clk (core_clk),
    .reset    (reset),
    .in_tick  (always_tick),
    .out_tick (div4_tick)
  );

  // External count input: falling edges after two flops, see R10
  edge_sync #(.FALLING(1'b1)) u_eci_sync (
    .core_clk  (core_clk),
    .reset     (reset),
    .pin       (external_count_input),
    .edge_tick (eci_tick)
  );

  // External oscillator, synchronised then divided, see R11
  edge_sync #(.FALLING(1'b0)) u_osc_sync (
    .core_clk  (core_clk),
    .reset     (reset),
    .pin       (ext_osc_in),
    .edge_tick (osc_edge)
  );

  tick_divider #(.DIV(counter_pkg::DIV_OSC)) u_osc_div (
    .core_clk (core_clk),
    .reset    (reset),
    .in_tick  (osc_edge),
    .out_tick (osc8_tick)
  );

  // Low-frequency oscillator, synchronised then divided, see R12
  edge_sync #(.FALLING(1'b0)) u_lfo_sync (
    .core_clk  (core_clk),
    .reset     (reset),
    .pin       (lfo_in),
    .edge_tick (lfo_edge)
  );

  tick_divider #(.DIV(counter_pkg::DIV_OSC)) u_lfo_div (
    .core_clk (core_clk),
    .reset    (reset),
    .in_tick  (lfo_edge),
    .out_tick (lfo8_tick)
  );

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  logic                  irq_enable_r, irq_enable_nxt;
  logic                  suspend_r, suspend_nxt;
  counter_pkg::timebase_t tb_sel_r, tb_sel_nxt;
  logic                  flag_r, flag_nxt;
  logic                  overflow_set;
  logic [7:0]            mode_read;

  always_comb begin
    irq_enable_nxt = irq_enable_r;
    suspend_nxt    = suspend_r;
    tb_sel_nxt     = tb_sel_r;
    flag_nxt       = flag_r;
    if (wr_mode) begin
      irq_enable_nxt = reg_wdata[counter_pkg::MODE_ENABLE_BIT];
      suspend_nxt    = reg_wdata[counter_pkg::MODE_SUSPEND_BIT];
      tb_sel_nxt     = counter_pkg::timebase_t'(
        reg_wdata[counter_pkg::MODE_SEL_MSB:counter_pkg::MODE_SEL_LSB]);
      // Writing zero clears; writing one leaves it alone, see R7
      if (!reg_wdata[counter_pkg::MODE_FLAG_BIT]) begin
        flag_nxt = 1'b0;
      end
    end
    // Hardware set beats a same-cycle clear, see R5
    if (overflow_set) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_enable_r <= counter_pkg::MODE_RESET[counter_pkg::MODE_ENABLE_BIT];
      suspend_r    <= counter_pkg::MODE_RESET[counter_pkg::MODE_SUSPEND_BIT];
      tb_sel_r     <= counter_pkg::TB_DIV12;
      flag_r       <= counter_pkg::MODE_RESET[counter_pkg::MODE_FLAG_BIT];
    end else begin
      irq_enable_r <= irq_enable_nxt;
      suspend_r    <= suspend_nxt;
      tb_sel_r     <= tb_sel_nxt;
      flag_r       <= flag_nxt;
    end
  end

  always_comb begin
    mode_read = counter_pkg::BYTE_ZERO;
    mode_read[counter_pkg::MODE_ENABLE_BIT]  = irq_enable_r;
    mode_read[counter_pkg::MODE_SEL_MSB:counter_pkg::MODE_SEL_LSB] = tb_sel_r;
    mode_read[counter_pkg::MODE_FLAG_BIT]    = flag_r;
    mode_read[counter_pkg::MODE_SUSPEND_BIT] = suspend_r;
  end

  // Request tracks the flag only while enabled, see R6
  assign overflow_irq = flag_r & irq_enable_r;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic [15:0] count_r, count_nxt;
  logic [7:0]  count_high;
  logic        src_tick;
  logic        hold;
  logic        count_en;

  always_comb begin
    case (tb_sel_r)
      counter_pkg::TB_DIV12:  src_tick = div12_tick.pulse;   // see R9
      counter_pkg::TB_DIV4:   src_tick = div4_tick.pulse;    // see R9
      counter_pkg::TB_TIMER0: src_tick = timer0_overflow;    // see R9
      counter_pkg::TB_ECI:    src_tick = eci_tick.pulse;     // see R10
      counter_pkg::TB_SYSCLK: src_tick = 1'b1;               // see R9
      counter_pkg::TB_EXTOSC: src_tick = osc8_tick.pulse;    // see R11
      counter_pkg::TB_LFO:    src_tick = lfo8_tick.pulse;    // see R12
      default:                src_tick = 1'b0;               // see R12
    endcase
  end

  // Idle stalls counting only when suspend is set, see R8 and R13
  assign hold     = suspend_r & cpu_idle;
  assign count_en = src_tick & ~hold;

  // Reads never enter this path, so counting is undisturbed, see R4
  always_comb begin
    count_nxt    = count_r;
    overflow_set = 1'b0;
    if (count_en) begin
      count_nxt = count_r + 16'h0001;
      overflow_set = (count_r == counter_pkg::CNT_MAX) & ~wr_low & ~wr_high;
    end
    // Byte writes load their half of the single 16-bit count, see R1
    if (wr_low) begin
      count_nxt[7:0] = reg_wdata;
    end
    if (wr_high) begin
      count_nxt[15:8] = reg_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_r <= counter_pkg::CNT_RESET;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count_high = count_r[15:8];

  // ----------------------------------------------------------------
  // Snapshot and read data
  // ----------------------------------------------------------------
  logic [7:0] snap_r, snap_nxt;
  logic       snap_valid_r, snap_valid_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // Low-byte read latches the high byte, see R2 and R3
  always_comb begin
    snap_nxt       = snap_r;
    snap_valid_nxt = snap_valid_r;
    if (rd_low) begin
      snap_nxt       = count_high;
      snap_valid_nxt = 1'b1;
    end else if (rd_high) begin
      snap_valid_nxt = 1'b0;
    end
  end

  always_comb begin
    rdata_nxt = counter_pkg::BYTE_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        counter_pkg::ADDR_LOW:  rdata_nxt = count_r[7:0];
        counter_pkg::ADDR_HIGH: rdata_nxt = snap_valid_r ? snap_r
                                                         : count_high;
        counter_pkg::ADDR_MODE: rdata_nxt = mode_read;
        default:                rdata_nxt = counter_pkg::BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      snap_r       <= counter_pkg::BYTE_ZERO;
      snap_valid_r <= 1'b0;
      rdata_r      <= counter_pkg::BYTE_ZERO;
    end else begin
      snap_r       <= snap_nxt;
      snap_valid_r <= snap_valid_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic wr_count;
  assign wr_count = wr_low | wr_high;

  sequence s_low_then_high;
    rd_low ##1 rd_high;
  endsequence

  sequence s_wrap;
    count_en && !wr_count && count_r == counter_pkg::CNT_MAX;
  endsequence

  property p_snapshot;
    @(posedge core_clk) disable iff (reset)
    s_low_then_high |=> reg_rdata == $past(count_high, 2);
  endproperty
  a_snapshot: assert property (p_snapshot)  // see R2
    else $error("High-byte read did not return the snapshot");

  property p_read_no_disturb;
    @(posedge core_clk) disable iff (reset)
    (reg_rd && count_en && !wr_count)
      |=> (count_r - $past(count_r)) == 16'h0001;
  endproperty
  a_read_no_disturb: assert property (p_read_no_disturb)  // see R4
    else $error("Read disturbed the count");

  property p_wrap_sets_flag;
    @(posedge core_clk) disable iff (reset)
    s_wrap |=> flag_r && count_r == counter_pkg::CNT_RESET;
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag)  // see R5
    else $error("Wrap did not set the overflow flag");

  property p_irq_gate;
    @(posedge core_clk) disable iff (reset)
    (wr_mode && !reg_wdata[counter_pkg::MODE_ENABLE_BIT]) |=> !overflow_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)  // see R6
    else $error("Interrupt request without enable");

  property p_flag_sticky;
    @(posedge core_clk) disable iff (reset)
    (flag_r && !wr_mode) |=> flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)  // see R7
    else $error("Overflow flag cleared without software");

  property p_run_in_idle;
    @(posedge core_clk) disable iff (reset)
    (!suspend_r && cpu_idle && src_tick && !wr_count)
      |=> (count_r - $past(count_r)) == 16'h0001;
  endproperty
  a_run_in_idle: assert property (p_run_in_idle)  // see R8
    else $error("Counter stopped in idle without suspend");

  property p_div12_spacing;
    @(posedge core_clk) disable iff (reset)
    div12_tick.pulse |=> (!div12_tick.pulse)[*8] ##1 !div12_tick.pulse
      ##1 !div12_tick.pulse ##1 !div12_tick.pulse ##1 div12_tick.pulse;
  endproperty
  a_div12_spacing: assert property (p_div12_spacing)  // see R9
    else $error("Clock/12 tick spacing wrong");

  property p_eci_counts;
    @(posedge core_clk) disable iff (reset)
    (tb_sel_r == counter_pkg::TB_ECI && eci_tick.pulse && !hold
      && !wr_count) |=> (count_r - $past(count_r)) == 16'h0001;
  endproperty
  a_eci_counts: assert property (p_eci_counts)  // see R10
    else $error("External count edge not counted");

  property p_osc_counts;
    @(posedge core_clk) disable iff (reset)
    (tb_sel_r == counter_pkg::TB_EXTOSC && !osc8_tick.pulse && !wr_count)
      |=> $stable(count_r);
  endproperty
  a_osc_counts: assert property (p_osc_counts)  // see R11
    else $error("Counted without a divided oscillator tick");

  property p_reserved_still;
    @(posedge core_clk) disable iff (reset)
    (tb_sel_r == counter_pkg::TB_RESERVED && !wr_count) |=> $stable(count_r);
  endproperty
  a_reserved_still: assert property (p_reserved_still)  // see R12
    else $error("Reserved timebase counted");

  property p_idle_hold;
    @(posedge core_clk) disable iff (reset)
    (hold && !wr_count) |=> $stable(count_r);
  endproperty
  a_idle_hold: assert property (p_idle_hold)  // see R13
    else $error("Counter moved while suspended in idle");

endmodule

// *** verif/test_counter_timebase.sv ***
// Self-checking testbench for the counter timebase block
`timescale 1ns/1ns
module test_counter_timebase;

  // ----------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------
  logic        core_clk;
  logic        reset;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        cpu_idle;
  logic        timer0_overflow;
  logic        external_count_input;
  logic        ext_osc_in;
  logic        lfo_in;
  logic        overflow_irq;

  // Kind 0 absolute, 1 relative to previous read, 2 record only
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] val;
  } note_t;

  note_t       notes[$];
  note_t       cur;
  logic        rd_d;
  logic [7:0]  last_v;
  logic [7:0]  exp_v;
  logic [31:0] rng;
  logic [15:0] v;
  int          errors;
  int          num_checks;

  counter_timebase dut (
    .core_clk             (core_clk),
    .reset                (reset),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .cpu_idle             (cpu_idle),
    .timer0_overflow      (timer0_overflow),
    .external_count_input (external_count_input),
    .ext_osc_in           (ext_osc_in),
    .lfo_in               (lfo_in),
    .overflow_irq         (overflow_irq)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic compare(input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic r, input logic [1:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 2'h0, 8'h00);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [1:0] a, input logic [1:0] k,
                    input logic [7:0] e);
    notes.push_back('{kind: k, val: e});
    bus(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic t0(input int n);
    repeat (n) begin
      idle(1);
      timer0_overflow <= 1'b1;
      idle(1);
      timer0_overflow <= 1'b0;
    end
  endtask

  task automatic pin(input logic [2:0] c, input logic lv);
    if (c == 3'h3) external_count_input <= lv;
    else if (c == 3'h5) ext_osc_in <= lv;
    else lfo_in <= lv;
  endtask

  task automatic chk_irq(input logic e);
    idle(1);
    @(negedge core_clk);
    compare({7'h00, e}, {7'h00, overflow_irq});
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and read-data monitor
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end

  always @(posedge core_clk) rd_d <= reg_rd;

  always @(negedge core_clk) begin
    if (rd_d) begin
      if (notes.size() == 0) begin
        compare(8'h00, 8'hff);
      end else begin
        cur   = notes.pop_front();
        exp_v = (cur.kind == 2'h1) ? last_v + cur.val : cur.val;
        if (cur.kind != 2'h2) compare(exp_v, reg_rdata);
        last_v = reg_rdata;
      end
    end else begin
      compare(8'h00, reg_rdata);
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  counter_pkg::timebase_t codes[4];
  int                     dlt[4];
  logic [2:0]             pc[3];
  int                     pd[3];

  initial begin
    codes = '{counter_pkg::TB_DIV12, counter_pkg::TB_DIV4,
              counter_pkg::TB_SYSCLK, counter_pkg::TB_RESERVED};
    dlt = '{4, 12, 48, 0};
    pc  = '{3'h3, 3'h5, 3'h6};
    pd  = '{16, 2, 2};
    rng = 32'd95;
    rd_d = 1'b0;
    last_v = 8'h00;
    errors = 0;
    num_checks = 0;
    reset = 1'b1;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cpu_idle = 1'b0;
    timer0_overflow = 1'b0;
    external_count_input = 1'b1;
    ext_osc_in = 1'b0;
    lfo_in = 1'b0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    rd(counter_pkg::ADDR_MODE, 2'h0, counter_pkg::MODE_RESET);
    rd(counter_pkg::ADDR_LOW, 2'h0, 8'h00);
    rd(counter_pkg::ADDR_HIGH, 2'h0, 8'h00);
    // Frozen timebase: load a random count and read it back
    wr(counter_pkg::ADDR_MODE, 8'h04);
    v = 16'(xs());
    wr(counter_pkg::ADDR_LOW, v[7:0]);
    wr(counter_pkg::ADDR_HIGH, v[15:8]);
    rd(counter_pkg::ADDR_LOW, 2'h0, v[7:0]);
    rd(counter_pkg::ADDR_HIGH, 2'h0, v[15:8]);
    rd(counter_pkg::ADDR_LOW, 2'h0, v[7:0]);
    wr(counter_pkg::ADDR_HIGH, ~v[15:8]);
    rd(counter_pkg::ADDR_HIGH, 2'h0, v[15:8]);
    rd(counter_pkg::ADDR_HIGH, 2'h0, ~v[15:8]);
    // Timer 0 overflow pulses
    rd(counter_pkg::ADDR_LOW, 2'h2, 8'h00);
    v = 16'(xs() % 8) + 16'h1;
    t0(int'(v));
    idle(3);
    rd(counter_pkg::ADDR_LOW, 2'h1, v[7:0]);
    // Clock-derived timebases and the reserved code over a 48-cycle span
    for (int i = 0; i < 4; i++) begin
      wr(counter_pkg::ADDR_MODE, {4'h0, 3'(codes[i]), 1'b0});
      idle(2);
      rd(counter_pkg::ADDR_LOW, 2'h2, 8'h00);
      idle(47);
      rd(counter_pkg::ADDR_LOW, 2'h1, 8'(dlt[i]));
    end
    wr(counter_pkg::ADDR_MODE, 8'h08);
    rd(counter_pkg::ADDR_LOW, 2'h2, 8'h00);
    rd(counter_pkg::ADDR_LOW, 2'h1, 8'h01);
    rd(counter_pkg::ADDR_HIGH, 2'h2, 8'h00);
    rd(counter_pkg::ADDR_LOW, 2'h2, 8'h00);
    rd(counter_pkg::ADDR_LOW, 2'h1, 8'h01);
    // Pin-driven timebases
    for (int i = 0; i < 3; i++) begin
      wr(counter_pkg::ADDR_MODE, {4'h0, pc[i], 1'b0});
      idle(2);
      rd(counter_pkg::ADDR_LOW, 2'h2, 8'h00);
      repeat (16) begin
        pin(pc[i], pc[i] != 3'h3);
        idle(4);
        pin(pc[i], pc[i] == 3'h3);
        idle(4);
      end
      idle(8);
      rd(counter_pkg::ADDR_LOW, 2'h1, 8'(pd[i]));
    end
    // Processor idle with and without suspend
    cpu_idle <= 1'b1;
    wr(counter_pkg::ADDR_MODE, 8'h08);
    rd(counter_pkg::ADDR_LOW, 2'h2, 8'h00);
    idle(47);
    rd(counter_pkg::ADDR_LOW, 2'h1, 8'd48);
    wr(counter_pkg::ADDR_MODE, 8'h88);
    rd(counter_pkg::ADDR_LOW, 2'h2, 8'h00);
    idle(47);
    rd(counter_pkg::ADDR_LOW, 2'h1, 8'h00);
    cpu_idle <= 1'b0;
    idle(2);
    rd(counter_pkg::ADDR_LOW, 2'h2, 8'h00);
    idle(47);
    rd(counter_pkg::ADDR_LOW, 2'h1, 8'd48);
    // Wrap, flag and interrupt request
    wr(counter_pkg::ADDR_MODE, 8'h04);
    wr(counter_pkg::ADDR_LOW, 8'hff);
    wr(counter_pkg::ADDR_HIGH, 8'hff);
    t0(1);
    idle(3);
    rd(counter_pkg::ADDR_MODE, 2'h0, 8'h44);
    chk_irq(1'b0);
    wr(counter_pkg::ADDR_MODE, 8'h45);
    chk_irq(1'b1);
    idle(20);
    chk_irq(1'b1);
    rd(counter_pkg::ADDR_LOW, 2'h0, 8'h00);
    rd(counter_pkg::ADDR_HIGH, 2'h0, 8'h00);
    wr(counter_pkg::ADDR_MODE, 8'h05);
    chk_irq(1'b0);
    rd(counter_pkg::ADDR_MODE, 2'h0, 8'h05);
    wr(counter_pkg::ADDR_MODE, 8'hff);
    rd(counter_pkg::ADDR_MODE, 2'h0, 8'h8f);
    // Unmapped address
    wr(2'h3, 8'(xs() >> 24));
    rd(2'h3, 2'h0, 8'h00);
    idle(4);
    compare(8'h00, 8'(notes.size()));
    tally_and_finish();
  end

endmodule
